// ==== hdl/timer16_byte_access_core.v ====
`timescale 1ns/10ps
`include "timer16_map.vh"
module timer16_byte_access_core (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        ext_count_pin,
	input  wire        capture_pin,
	input  wire        comparator_in,
	output reg         compare_out_a,
	output reg         compare_out_b,
	output reg  [3:0]  timer_irq,
	output wire        at_bottom,
	output wire        at_max,
	output wire        at_top
);
	// counter, compare and capture state
	reg  [15:0] timer_count;     // live counter
	reg  [15:0] compare_reg_a;   // active compare a
	reg  [15:0] compare_reg_b;   // active compare b
	reg  [15:0] cmp_buf_a;       // software side of compare a
	reg  [15:0] cmp_buf_b;       // software side of compare b
	reg  [15:0] capture_reg;     // captured timestamp or top
	reg  [7:0]  hi_latch;        // shared high-byte latch
	reg  [7:0]  snap_hi;         // upper byte sampled at setup
	reg  [7:0]  timer_ctrl_a;    // mode bits 1:0, force strobes
	reg  [7:0]  timer_ctrl_b;    // clock select, mode 3:2, capture setup
	reg  [3:0]  timer_flag_reg;  // sticky event flags
	reg  [3:0]  timer_mask_reg;  // per-flag enables
	reg  [9:0]  prescale;        // free running divider
	reg  [2:0]  ext_sync;        // pin sync pair plus history
	reg  [1:0]  cap_sync;        // capture pin sync pair
	reg  [1:0]  cmp_sync;        // comparator sync pair
	reg  [3:0]  cap_hist;        // filter shift register
	reg         cap_level;       // filtered capture level
	reg         cap_prev;        // previous filtered level
	reg  [15:0] top_value;       // current top
	reg         timer_tick;      // selected tick
	reg  [7:0]  rd_mux;          // read data before register
	reg         addr_ok;         // address decodes
	// decoded strobes and selections
	wire [3:0]  wgm;             // waveform mode
	wire        setup;           // apb setup cycle
	wire        wr_acc;          // write taking effect
	wire        rd_acc;          // read taking effect
	wire [7:0]  wbyte;           // write data byte
	wire        pwm_mode;        // compare buffering at top
	wire        cap_is_top;      // capture defines top
	wire        cmpa_is_top;     // compare a defines top
	wire        cap_src;         // selected capture source
	wire        cap_edge;        // capture trigger
	wire        at_top_tick;     // wrap on this tick
	wire        match_a;         // compare a hit on a tick
	wire        match_b;         // compare b hit on a tick
	wire [3:0]  flag_set;        // hardware events this cycle
	wire [3:0]  flag_clr;        // software clears this cycle

	// bus strobes; every write and read side effect lands in the access phase
	assign wgm     = {timer_ctrl_b[`CTRLB_WGM3], timer_ctrl_b[`CTRLB_WGM2], timer_ctrl_a[1:0]};
	assign setup   = psel & ~penable;
	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & penable & ~pwrite;
	assign wbyte   = pwdata[7:0];
	// one wait-free access cycle; unmapped addresses answer with an error
	assign pready  = penable;
	assign pslverr = psel & penable & ~addr_ok;

	// status levels straight from the counter, no register delay
	assign at_bottom = (timer_count == `VAL_BOTTOM);
	assign at_max    = (timer_count == `VAL_MAX);
	assign at_top    = (timer_count == top_value);

	// modes that take top from a register
	assign cap_is_top  = (wgm == 4'd8) | (wgm == 4'd10) | (wgm == 4'd12) | (wgm == 4'd14);
	assign cmpa_is_top = (wgm == 4'd4) | (wgm == 4'd9) | (wgm == 4'd11) | (wgm == 4'd15);
	// every mode but normal and the two clear-on-match modes is pwm
	assign pwm_mode    = ~((wgm == 4'd0) | (wgm == 4'd4) | (wgm == 4'd12));

	// top selection by mode
	// a register top follows the active copy, never the software buffer
	always @* begin
		case (wgm)
			4'd1, 4'd5:                 top_value = `VAL_TOP8;
			4'd2, 4'd6:                 top_value = `VAL_TOP9;
			4'd3, 4'd7:                 top_value = `VAL_TOP10;
			4'd4, 4'd9, 4'd11, 4'd15:   top_value = compare_reg_a;
			4'd8, 4'd10, 4'd12, 4'd14:  top_value = capture_reg;
			default:                    top_value = `VAL_MAX;
		endcase
	end

	// address decode; 'ok' only drives the slave error, writes decode paddr on their own
	// only the low byte of each word carries data, the rest reads zero
	always @* begin
		addr_ok = 1'b1;
		if (paddr == `ADDR_COUNT_LO) begin
			rd_mux = timer_count[7:0];
		end else if (paddr == `ADDR_COUNT_HI) begin
			rd_mux = hi_latch;
		end else if (paddr == `ADDR_CMPA_LO) begin
			rd_mux = cmp_buf_a[7:0];
		end else if (paddr == `ADDR_CMPA_HI) begin
			rd_mux = cmp_buf_a[15:8];
		end else if (paddr == `ADDR_CMPB_LO) begin
			rd_mux = cmp_buf_b[7:0];
		end else if (paddr == `ADDR_CMPB_HI) begin
			rd_mux = cmp_buf_b[15:8];
		end else if (paddr == `ADDR_CAP_LO) begin
			rd_mux = capture_reg[7:0];
		end else if (paddr == `ADDR_CAP_HI) begin
			rd_mux = hi_latch;
		end else if (paddr == `ADDR_CTRL_A) begin
			rd_mux = {4'h0, timer_ctrl_a[3:0] & 4'b0011}; // strobes read zero
		end else if (paddr == `ADDR_CTRL_B) begin
			rd_mux = timer_ctrl_b;
		end else if (paddr == `ADDR_FLAG) begin
			rd_mux = {4'h0, timer_flag_reg};
		end else if (paddr == `ADDR_MASK) begin
			rd_mux = {4'h0, timer_mask_reg};
		end else begin
			rd_mux  = `RST_BYTE;
			addr_ok = 1'b0;
		end
	end

	// read data is taken at setup so the access cycle answers at once; the
	// upper byte is snapped at the same edge so the latch copy is coherent
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			snap_hi <= `RST_BYTE;
		end else if (setup) begin
			prdata  <= {24'h00_0000, rd_mux};
			snap_hi <= (paddr == `ADDR_CAP_LO) ? capture_reg[15:8] : timer_count[15:8];
		end
	end

	// shared high-byte latch
	// a write to any upper byte, or a low read of count or capture, moves it;
	// compare reads leave it alone so a pending wide write survives them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_latch <= `RST_BYTE;
		end else if (wr_acc && ((paddr == `ADDR_COUNT_HI) || (paddr == `ADDR_CMPA_HI) ||
				(paddr == `ADDR_CMPB_HI) || (paddr == `ADDR_CAP_HI))) begin
			hi_latch <= wbyte;
		end else if (rd_acc && ((paddr == `ADDR_COUNT_LO) || (paddr == `ADDR_CAP_LO))) begin
			hi_latch <= snap_hi;
		end
	end

	// plain byte registers; force strobes live one cycle only
	// a write that sets a strobe comes last and so wins over the self clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_ctrl_a   <= `RST_BYTE;
			timer_ctrl_b   <= `RST_BYTE;
			timer_mask_reg <= 4'h0;
		end else begin
			timer_ctrl_a[`CTRLA_FORCE_A] <= 1'b0;
			timer_ctrl_a[`CTRLA_FORCE_B] <= 1'b0;
			if (wr_acc && paddr == `ADDR_CTRL_A) begin
				timer_ctrl_a <= {4'h0, wbyte[3:0]};
			end
			if (wr_acc && paddr == `ADDR_CTRL_B) begin
				timer_ctrl_b <= wbyte;
			end
			if (wr_acc && paddr == `ADDR_MASK) begin
				timer_mask_reg <= wbyte[3:0];
			end
		end
	end

	// prescaler runs regardless of clock select
	// limitation: the first prescaled tick after enable may come early
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= 10'h000;
		end else begin
			prescale <= prescale + 10'h001;
		end
	end

	// input synchronisers; first stage feeds only the second
	// the third count pin stage is edge history only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync <= 3'b000;
			cap_sync <= 2'b00;
			cmp_sync <= 2'b00;
		end else begin
			ext_sync <= {ext_sync[1:0], ext_count_pin};
			cap_sync <= {cap_sync[0], capture_pin};
			cmp_sync <= {cmp_sync[0], comparator_in};
		end
	end

	// tick source and edge select; select 0 stops the counter
	// an external tick lags its pin edge by about three cycles
	always @* begin
		case (timer_ctrl_b[2:0])
			3'd1:    timer_tick = 1'b1;
			3'd2:    timer_tick = (prescale[2:0] == 3'h7);
			3'd3:    timer_tick = (prescale[5:0] == 6'h3F);
			3'd4:    timer_tick = (prescale[7:0] == 8'hFF);
			3'd5:    timer_tick = (prescale == 10'h3FF);
			3'd6:    timer_tick = ext_sync[2] & ~ext_sync[1];
			3'd7:    timer_tick = ~ext_sync[2] & ext_sync[1];
			default: timer_tick = 1'b0;
		endcase
	end

	// capture filter: level changes only after four equal samples,
	// which costs four cycles of latency when enabled
	assign cap_src = timer_ctrl_b[`CTRLB_SRC_CMP] ? cmp_sync[1] : cap_sync[1];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_hist  <= 4'h0;
			cap_level <= 1'b0;
			cap_prev  <= 1'b0;
		end else begin
			cap_hist <= {cap_hist[2:0], cap_src};
			if (!timer_ctrl_b[`CTRLB_FILTER]) begin
				cap_level <= cap_src;
			end else if (cap_hist == 4'hF) begin
				cap_level <= 1'b1;
			end else if (cap_hist == 4'h0) begin
				cap_level <= 1'b0;
			end
			cap_prev <= cap_level;
		end
	end
	assign cap_edge = ~cap_is_top & (timer_ctrl_b[`CTRLB_EDGE] ? (cap_level & ~cap_prev) :
		(~cap_level & cap_prev));

	// top and compare events qualify on the tick so a stopped counter raises none of them
	assign at_top_tick = timer_tick & (timer_count == top_value);
	assign match_a     = timer_tick & (timer_count == compare_reg_a);
	assign match_b     = timer_tick & (timer_count == compare_reg_b);

	// counter: software write wins over wrap and count
	// the wrap happens on the tick that finds the counter at top
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count <= `VAL_BOTTOM;
		end else if (wr_acc && paddr == `ADDR_COUNT_LO) begin
			timer_count <= {hi_latch, wbyte};
		end else if (at_top_tick) begin
			timer_count <= `VAL_BOTTOM;
		end else if (timer_tick) begin
			timer_count <= timer_count + 16'h0001;
		end
	end

	// compare buffers; pwm modes move them across only at top
	// outside pwm the active copy trails the buffer by one cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_buf_a     <= 16'h0000;
			cmp_buf_b     <= 16'h0000;
			compare_reg_a <= 16'h0000;
			compare_reg_b <= 16'h0000;
		end else begin
			if (wr_acc && paddr == `ADDR_CMPA_LO) begin
				cmp_buf_a <= {hi_latch, wbyte};
			end
			if (wr_acc && paddr == `ADDR_CMPB_LO) begin
				cmp_buf_b <= {hi_latch, wbyte};
			end
			if (!pwm_mode || at_top_tick) begin
				compare_reg_a <= cmp_buf_a;
				compare_reg_b <= cmp_buf_b;
			end
		end
	end

	// capture register: timestamp on edge, or top value by software
	// set the mode first: a top write in any other mode is dropped
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_reg <= 16'h0000;
		end else if (wr_acc && paddr == `ADDR_CAP_LO && cap_is_top) begin
			capture_reg <= {hi_latch, wbyte};
		end else if (cap_edge) begin
			capture_reg <= timer_count;
		end
	end

	// flags: a set in the clearing cycle survives
	// the mask only gates the request, never the flag itself
	assign flag_set[`FLAG_OVF]  = cap_is_top | cmpa_is_top ? at_top_tick :
		(timer_tick & (timer_count == `VAL_MAX) | at_top_tick);
	assign flag_set[`FLAG_CMPB] = match_b;
	assign flag_set[`FLAG_CMPA] = match_a;
	assign flag_set[`FLAG_CAP]  = cap_edge | (cap_is_top & at_top_tick);
	// a one written clears its flag; zeros leave flags alone
	assign flag_clr = (wr_acc && paddr == `ADDR_FLAG) ? wbyte[3:0] : 4'h0;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_flag_reg <= 4'h0;
			timer_irq      <= 4'h0;
		end else begin
			timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
			timer_irq      <= timer_flag_reg & timer_mask_reg;
		end
	end

	// force strobes only act outside pwm, where a toggle is meaningful
	// waveform outputs: toggle on match outside pwm, set at bottom and
	// clear on match in pwm; in pwm, compare a holds low when it is top
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_out_a <= 1'b0;
			compare_out_b <= 1'b0;
		end else if (pwm_mode) begin
			if (cmpa_is_top) begin
				compare_out_a <= 1'b0;
			end else if (match_a) begin
				compare_out_a <= 1'b0;
			end else if (at_top_tick) begin
				compare_out_a <= 1'b1;
			end
			if (match_b) begin
				compare_out_b <= 1'b0;
			end else if (at_top_tick) begin
				compare_out_b <= 1'b1;
			end
		end else begin
			if (match_a || timer_ctrl_a[`CTRLA_FORCE_A]) begin
				compare_out_a <= ~compare_out_a;
			end
			if (match_b || timer_ctrl_a[`CTRLA_FORCE_B]) begin
				compare_out_b <= ~compare_out_b;
			end
		end
	end
endmodule // timer16_byte_access_core

// ==== hdl/timer16_map.vh ====
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// register byte addresses
`define ADDR_COUNT_LO   8'h00
`define ADDR_COUNT_HI   8'h04
`define ADDR_CMPA_LO    8'h08
`define ADDR_CMPA_HI    8'h0C
`define ADDR_CMPB_LO    8'h10
`define ADDR_CMPB_HI    8'h14
`define ADDR_CAP_LO     8'h18
`define ADDR_CAP_HI     8'h1C
`define ADDR_CTRL_A     8'h20
`define ADDR_CTRL_B     8'h24
`define ADDR_FLAG       8'h28
`define ADDR_MASK       8'h2C
// field positions
`define CTRLA_FORCE_A   3
`define CTRLA_FORCE_B   2
`define CTRLB_EDGE      6
`define CTRLB_FILTER    7
`define CTRLB_SRC_CMP   5
`define CTRLB_WGM3      4
`define CTRLB_WGM2      3
`define FLAG_OVF        0
`define FLAG_CMPB       1
`define FLAG_CMPA       2
`define FLAG_CAP        3
// limits
`define VAL_BOTTOM      16'h0000
`define VAL_MAX         16'hFFFF
`define VAL_TOP8        16'h00FF
`define VAL_TOP9        16'h01FF
`define VAL_TOP10       16'h03FF
`define RST_BYTE        8'h00
`define FILTER_LEN      4
`endif

// ==== sim/timer16_asserts.sv ====
`timescale 1ns/10ps
`include "timer16_map.vh"
// watches the apb side and the bottom and max status pins of the timer core
module timer16_asserts (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pslverr,
	input wire [3:0]  timer_irq,
	input wire        at_bottom,
	input wire        at_max
);
	wire       acc = psel && penable;             // access phase
	wire       wr  = acc && pwrite;
	wire       rd  = acc && !pwrite;
	wire       map = (paddr[1:0] == 2'b00) && (paddr <= `ADDR_MASK);
	reg  [7:0] lat;                               // mirror of the shared latch
	reg        lk;                                // mirror holds a known value
	reg [15:0] ca;                                // mirror of compare a buffer
	reg        ck;
	// mirror only what the bus itself reveals; a low read of count or
	// capture loads hidden counter or capture bits, so the mirror goes unknown there
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat <= 8'h00;
			lk <= 1'b0;
			ca <= 16'h0000;
			ck <= 1'b0;
		end else if (wr && paddr[2] && paddr < `ADDR_CTRL_A) begin
			lat <= pwdata[7:0];
			lk <= 1'b1;
		end else if (rd && (paddr == `ADDR_COUNT_LO || paddr == `ADDR_CAP_LO)) begin
			lk <= 1'b0;
		end else if (wr && paddr == `ADDR_CMPA_LO) begin
			ca <= {lat, pwdata[7:0]};
			ck <= lk;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SLVERR: assert property (acc |-> pslverr == !map)
		else $error("slave error does not match address map");
	AST_RD_UPPER: assert property (rd |-> prdata[31:8] == 24'h00_0000)
		else $error("read data wider than a byte");
	AST_STROBE: assert property (rd && paddr == `ADDR_CTRL_A |-> prdata[3:2] == 2'b00)
		else $error("force strobes read back as one");
	AST_LATCH_HI: assert property (rd && lk && (paddr == `ADDR_COUNT_HI ||
		paddr == `ADDR_CAP_HI) |-> prdata[7:0] == lat)
		else $error("upper byte read is not the latch");
	AST_CMPA_HI: assert property (rd && ck && paddr == `ADDR_CMPA_HI |-> prdata[7:0] == ca[15:8])
		else $error("compare upper byte read wrong");
	AST_CMPA_LO: assert property (rd && ck && paddr == `ADDR_CMPA_LO |-> prdata[7:0] == ca[7:0])
		else $error("compare low byte read wrong");
	AST_IRQ_MASK: assert property (wr && paddr == `ADDR_MASK && pwdata[3:0] == 4'h0
		|-> ##2 timer_irq == 4'h0)
		else $error("request seen while fully masked");
	AST_BOT_MAX: assert property (!(at_bottom && at_max))
		else $error("bottom and max together");
	cover property (rd && lk && paddr == `ADDR_COUNT_HI);
	cover property (at_max ##[1:20] at_bottom);
	cover property (timer_irq[`FLAG_CMPA]);
endmodule // timer16_asserts

bind timer16_byte_access_core timer16_asserts i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr),
	.timer_irq(timer_irq), .at_bottom(at_bottom), .at_max(at_max)
);

// ==== sim/cpu_bus_model.sv ====
`timescale 1ns/10ps
// processor side: byte transfers over apb, one at a time, no interrupts,
// so every byte pair runs unbroken
module cpu_bus_model (
	input  wire        pclk,
	input  wire [31:0] prdata,
	input  wire        pready,
	output reg         psel,
	output reg         penable,
	output reg         pwrite,
	output reg  [7:0]  paddr,
	output reg  [31:0] pwdata
);
	reg [7:0] junk; // read data of writes
	// bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// one transfer; released lines are inverted so stale values never pass
	task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~pwdata;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		xfer(1'b1, a, d, junk);
	endtask
	task rd(input [7:0] a, output [7:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask
	// wide write: upper byte into the latch, then the low byte
	task wr16(input [7:0] a, input [15:0] v);
		wr(a + 8'h04, v[15:8]);
		wr(a, v[7:0]);
	endtask
	// wide read: low byte first, which loads the latch for count and capture
	task rd16(input [7:0] a, output [15:0] v);
		rd(a, v[7:0]);
		rd(a + 8'h04, v[15:8]);
	endtask
endmodule // cpu_bus_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`include "timer16_map.vh"
module tb_top;
	reg         pclk;
	reg         presetn;
	reg         ext_count_pin;
	reg         capture_pin;
	reg         comparator_in;
	wire        psel;
	wire        penable;
	wire        pwrite;
	wire [7:0]  paddr;
	wire [31:0] pwdata;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire [3:0]  timer_irq;
	wire        at_bottom;
	wire        at_max;
	wire        at_top;
	wire        compare_out_a;
	wire        compare_out_b;
	integer     mismatches;
	integer     checks;
	integer     i;
	reg  [15:0] v;
	reg  [7:0]  b;
	reg  [7:0]  a;
	// 200 MHz clock
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;
	timer16_byte_access_core i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
		.capture_pin(capture_pin), .comparator_in(comparator_in),
		.compare_out_a(compare_out_a), .compare_out_b(compare_out_b), .timer_irq(timer_irq),
		.at_bottom(at_bottom), .at_max(at_max), .at_top(at_top)
	);
	cpu_bus_model i_cpu (
		.pclk(pclk), .prdata(prdata), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
	);
	// compare and count
	task chk(input string n, input [15:0] got, input [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	// let registered outputs settle before looking at them
	task settle;
		repeat (2) @(negedge pclk);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// poll the flag register until a bit sets, bounded
	task poll(input integer p);
		integer n;
		n = 0;
		b = 8'h00;
		while (b[p] !== 1'b1 && n < 40) begin
			i_cpu.rd(`ADDR_FLAG, b);
			n = n + 1;
		end
		chk("flag", {15'h0000, b[p]}, 16'h0001);
	endtask
	// watchdog, far beyond the expected run
	initial begin
		#200000;
		mismatches = mismatches + 1;
		wrap_up;
	end
	initial begin
		mismatches = 0;
		checks = 0;
		presetn = 1'b0;
		ext_count_pin = 1'b0;
		capture_pin = 1'b0;
		comparator_in = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk("bottom", {15'h0000, at_bottom}, 16'h0001);
		a = `ADDR_CTRL_A;
		for (i = 0; i < 5; i = i + 1) begin
			i_cpu.rd(a, b);
			chk("reset value", {8'h00, b}, 16'h0000);
			a = a + 8'h04;
		end
		i_cpu.wr(`ADDR_CTRL_A, 8'h0F);
		i_cpu.rd(`ADDR_CTRL_A, b);
		chk("ctrl_a", {8'h00, b}, 16'h0003);
		i_cpu.wr(`ADDR_CTRL_A, 8'h0C);
		settle;
		chk("force", {14'h0000, compare_out_a, compare_out_b}, 16'h0003);
		i_cpu.wr16(`ADDR_COUNT_LO, 16'h01FF);
		i_cpu.rd16(`ADDR_COUNT_LO, v);
		chk("count", v, 16'h01FF);
		i_cpu.wr(`ADDR_CMPB_HI, 8'h55);
		i_cpu.wr(`ADDR_COUNT_LO, 8'h66);
		i_cpu.rd16(`ADDR_COUNT_LO, v);
		chk("shared latch", v, 16'h5566);
		i_cpu.wr16(`ADDR_CMPA_LO, 16'h1234);
		i_cpu.wr(`ADDR_COUNT_HI, 8'hAB);
		i_cpu.rd16(`ADDR_CMPA_LO, v);
		chk("cmpa", v, 16'h1234);
		i_cpu.rd(`ADDR_COUNT_HI, b);
		chk("latch", {8'h00, b}, 16'h00AB);
		i_cpu.rd(8'h30, b);
		chk("unmapped", {8'h00, b}, 16'h0000);
		i_cpu.wr16(`ADDR_COUNT_LO, 16'hFFFF);
		settle;
		chk("max", {14'h0000, at_max, at_bottom}, 16'h0002);
		i_cpu.wr(`ADDR_CTRL_B, 8'h01);
		poll(`FLAG_OVF);
		i_cpu.wr(`ADDR_CTRL_B, 8'h00);
		i_cpu.wr(`ADDR_FLAG, 8'h0F);
		i_cpu.rd(`ADDR_FLAG, b);
		chk("flag clear", {8'h00, b}, 16'h0000);
		// fixed tops of the 8, 9 and 10 bit modes, clock stopped
		for (i = 1; i < 4; i = i + 1) begin
			i_cpu.wr(`ADDR_CTRL_A, i[7:0]);
			v = (16'h0100 << (i - 1)) - 16'h0001;
			i_cpu.wr16(`ADDR_COUNT_LO, v);
			settle;
			chk("fixed top", {15'h0000, at_top}, 16'h0001);
			i_cpu.wr16(`ADDR_COUNT_LO, v - 16'h0001);
			settle;
			chk("below top", {15'h0000, at_top}, 16'h0000);
		end
		i_cpu.wr(`ADDR_CTRL_A, 8'h00);
		i_cpu.wr16(`ADDR_CAP_LO, 16'h7788);
		i_cpu.rd16(`ADDR_CAP_LO, v);
		chk("cap locked", v, 16'h0000);
		i_cpu.wr(`ADDR_CTRL_B, 8'h18);
		i_cpu.wr16(`ADDR_CAP_LO, 16'h0300);
		i_cpu.rd16(`ADDR_CAP_LO, v);
		chk("cap as top", v, 16'h0300);
		i_cpu.wr16(`ADDR_COUNT_LO, 16'h0300);
		settle;
		chk("cap top", {15'h0000, at_top}, 16'h0001);
		i_cpu.wr(`ADDR_CTRL_B, 8'h08);
		i_cpu.wr16(`ADDR_COUNT_LO, 16'h1234);
		settle;
		chk("cmpa top", {15'h0000, at_top}, 16'h0001);
		// pwm mode with compare a as top: top stays buffered, output held low
		i_cpu.wr(`ADDR_CTRL_B, 8'h18);
		i_cpu.wr(`ADDR_CTRL_A, 8'h03);
		i_cpu.wr16(`ADDR_CMPA_LO, 16'h0400);
		settle;
		chk("cmpa buffered", {14'h0000, compare_out_a, at_top}, 16'h0001);
		i_cpu.wr(`ADDR_CTRL_A, 8'h00);
		i_cpu.wr(`ADDR_CTRL_B, 8'h00);
		// both compares hit while counting up from zero
		i_cpu.wr16(`ADDR_CMPA_LO, 16'h0010);
		i_cpu.wr16(`ADDR_CMPB_LO, 16'h0020);
		i_cpu.wr16(`ADDR_COUNT_LO, 16'h0000);
		i_cpu.wr(`ADDR_MASK, 8'h04);
		i_cpu.wr(`ADDR_CTRL_B, 8'h01);
		poll(`FLAG_CMPA);
		poll(`FLAG_CMPB);
		i_cpu.wr(`ADDR_CTRL_B, 8'h00);
		chk("irq", {12'h000, timer_irq}, 16'h0004);
		i_cpu.wr(`ADDR_MASK, 8'h00);
		repeat (3) @(posedge pclk);
		chk("irq masked", {12'h000, timer_irq}, 16'h0000);
		// pin counting: three rising and two falling edges
		for (i = 0; i < 2; i = i + 1) begin
			i_cpu.wr16(`ADDR_COUNT_LO, 16'h0000);
			i_cpu.wr(`ADDR_CTRL_B, 8'h07 - i[7:0]);
			repeat (5) begin
				repeat (4) @(posedge pclk);
				ext_count_pin <= ~ext_count_pin;
			end
			repeat (6) @(posedge pclk);
			i_cpu.wr(`ADDR_CTRL_B, 8'h00);
			ext_count_pin <= 1'b0;
			i_cpu.rd16(`ADDR_COUNT_LO, v);
			chk("pin count", v, 16'h0003 - i[15:0]);
		end
		// capture from the pin, then filtered from the comparator
		for (i = 0; i < 2; i = i + 1) begin
			capture_pin <= 1'b0;
			i_cpu.wr16(`ADDR_COUNT_LO, 16'h0040 + i[15:0]);
			i_cpu.wr(`ADDR_FLAG, 8'h08);
			i_cpu.wr(`ADDR_CTRL_B, (i == 0) ? 8'h40 : 8'hE0);
			if (i == 0)
				capture_pin <= 1'b1;
			else
				comparator_in <= 1'b1;
			poll(`FLAG_CAP);
			i_cpu.rd16(`ADDR_CAP_LO, v);
			chk("capture", v, 16'h0040 + i[15:0]);
			i_cpu.wr(`ADDR_CTRL_B, 8'h00);
		end
		wrap_up;
	end
endmodule // tb_top
